/* hdl/fan_ctrl_pkg.sv */
// constants, types and encodings shared by the fan speed link logic
// Function
// [RULE1] Set up the fan controller chip over the link before supervising it.
// [RULE2] Talk to the chip only by standard two-wire transfers, acting as master.
// [RULE3] Serial clock comes from the system clock through a programmable divider.
// [RULE4] Switch at 0 programs a target of about 2000 RPM.
// [RULE5] Switch at 1 programs a target of about 5000 RPM.
// [RULE6] After a new speed is written, wait for settling before checking.
// [RULE7] Any alarm flag read as set lights its indicator and keeps it lit.
// [RULE8] Pressing the clear button turns the latched indicators off.
// [RULE9] Flag bit 3 (aux input one low) drives indicator 3.
// [RULE10] Flag bits 2, 1, 0 drive indicators 2, 1, 0.
// [RULE11] Flag bits 4 to 7 are ignored.
// [RULE12] Poll the alarm flags periodically; update indicators after each read.
`default_nettype none

package fan_ctrl_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SCL_HZ         = 100_000;
  // four quarter phases per serial bit; a longest time, so rounded down
  localparam int unsigned QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned SETTLE_MIN_S   = 10;
  localparam int unsigned SETTLE_CYCLES  = SETTLE_MIN_S * CLK_HZ;
  localparam int unsigned POLL_MS        = 100;
  localparam int unsigned POLL_CYCLES    = POLL_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // chip map and setup values (plain defaults)
  localparam logic [6:0] CHIP_ADDR    = 7'h1B;
  localparam logic [7:0] REG_SPEED    = 8'h00;
  localparam logic [7:0] REG_CONFIG   = 8'h02;
  localparam logic [7:0] REG_ALARM    = 8'h0C;
  localparam logic [7:0] CONFIG_VALUE = 8'h0A;
  localparam logic [7:0] SPEED_LOW    = 8'h3C;
  localparam logic [7:0] SPEED_HIGH   = 8'h17;
  localparam logic [7:0] ALARM_RESET  = 8'h00;
  localparam logic [7:0] ALARM_USED   = 8'h0F;

  // ==========================================================================
  // link engine
  typedef enum logic [2:0] {
    ENG_IDLE    = 3'b000,
    ENG_START   = 3'b001,
    ENG_BIT     = 3'b010,
    ENG_RESTART = 3'b011,
    ENG_STOP    = 3'b100
  } eng_state_t;

  localparam logic [2:0] IDX_ADDR_WR = 3'h0;
  localparam logic [2:0] IDX_REG     = 3'h1;
  localparam logic [2:0] IDX_DATA    = 3'h2;
  localparam logic [2:0] IDX_ADDR_RD = 3'h3;
  localparam logic [2:0] IDX_READ    = 3'h4;
  localparam logic [3:0] ACK_SLOT    = 4'h8;

  typedef struct packed {
    logic       read;
    logic [6:0] dev;
    logic [7:0] regAddr;
    logic [7:0] data;
  } link_req_t;

  // ==========================================================================
  // supervisor
  typedef enum logic [2:0] {
    SUP_CONFIG = 3'b000,
    SUP_SPEED  = 3'b001,
    SUP_SETTLE = 3'b010,
    SUP_WAIT   = 3'b011,
    SUP_POLL   = 3'b100
  } sup_state_t;

endpackage

`default_nettype wire

/* hdl/link_master.sv */
// two-wire master engine: one register write or register read per request
`default_nettype none

module link_master #(
  parameter int unsigned QUARTER = fan_ctrl_pkg::QUARTER_CYCLES
) (
  input  wire logic                   clk_sys,  // system clock
  input  wire logic                   rst,      // async reset, high
  input  wire logic                   reqValid, // start a transfer
  input  wire fan_ctrl_pkg::link_req_t req,     // transfer description
  output logic                        reqReady, // engine idle
  output logic                        done,     // one-cycle end pulse
  output logic                        ackErr,   // missing acknowledge
  output logic [7:0]                  rdData,   // byte read
  input  wire logic                   sdaIn,    // data line level
  output logic                        sclOe,    // pull clock line low
  output logic                        sdaOe     // pull data line low
);

  if (QUARTER < 2 || QUARTER > 65535) begin : g_chk
    $error("link_master: QUARTER out of range");
  end

  typedef struct packed {
    fan_ctrl_pkg::eng_state_t st;
    logic [1:0]               qtr;
    logic [3:0]               slot;
    logic [2:0]               idx;
    logic [7:0]               sh;
    logic [7:0]               rd;
    logic                     ackErr;
    logic                     done;
    logic                     sclOe;
    logic                     sdaOe;
    logic [15:0]              pre;
    logic [2:0]               sdaSync;
    logic                     sdaF;
    fan_ctrl_pkg::link_req_t  req;
  } eng_regs_t;

  eng_regs_t r, n;

  function automatic logic [7:0] byteFor(input logic [2:0] idx,
                                         input fan_ctrl_pkg::link_req_t q);
    unique case (idx)
      fan_ctrl_pkg::IDX_ADDR_WR: byteFor = {q.dev, 1'b0};
      fan_ctrl_pkg::IDX_REG:     byteFor = q.regAddr;
      fan_ctrl_pkg::IDX_DATA:    byteFor = q.data;
      fan_ctrl_pkg::IDX_ADDR_RD: byteFor = {q.dev, 1'b1};
      default:                   byteFor = 8'hFF;
    endcase
  endfunction

  logic tick;
  logic rx;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.sdaSync = {r.sdaSync[1:0], sdaIn};
    if (r.sdaSync[2] == r.sdaSync[1]) begin
      n.sdaF = r.sdaSync[2];
    end
    // ==========================================================================
    // quarter-bit prescaler
    tick = (r.pre == 16'(QUARTER - 1)); // RULE3
    n.pre = tick ? 16'h0000 : 16'(r.pre + 16'h0001);
    rx = (r.idx == fan_ctrl_pkg::IDX_READ);
    if (tick && r.st != fan_ctrl_pkg::ENG_IDLE) begin
      n.qtr = 2'(r.qtr + 2'h1);
    end
    unique case (r.st)
      fan_ctrl_pkg::ENG_IDLE: begin
        n.sclOe = 1'b0;
        n.sdaOe = 1'b0;
        n.qtr = 2'h0;
        if (reqValid) begin
          n.req = req;
          n.st = fan_ctrl_pkg::ENG_START;
          n.pre = 16'h0000;
          n.ackErr = 1'b0;
        end
      end
      fan_ctrl_pkg::ENG_START: if (tick) begin
        unique case (r.qtr)
          2'h0: n.sdaOe = 1'b1; // RULE2
          2'h1: n.sclOe = 1'b1;
          2'h2: ;
          2'h3: begin
            n.st = fan_ctrl_pkg::ENG_BIT;
            n.idx = fan_ctrl_pkg::IDX_ADDR_WR;
            n.sh = byteFor(fan_ctrl_pkg::IDX_ADDR_WR, r.req);
            n.slot = 4'h0;
          end
        endcase
      end
      fan_ctrl_pkg::ENG_BIT: if (tick) begin
        unique case (r.qtr)
          // read bytes end in a released line, which is the final not-acknowledge
          2'h0: n.sdaOe = (r.slot < fan_ctrl_pkg::ACK_SLOT) && !rx && !r.sh[7];
          2'h1: n.sclOe = 1'b0;
          2'h2: begin
            if (r.slot < fan_ctrl_pkg::ACK_SLOT) begin
              n.sh = {r.sh[6:0], r.sdaF};
            end else if (!rx && r.sdaF) begin
              n.ackErr = 1'b1;
            end
          end
          2'h3: begin
            n.sclOe = 1'b1;
            if (r.slot != fan_ctrl_pkg::ACK_SLOT) begin
              n.slot = 4'(r.slot + 4'h1);
            end else if (r.ackErr) begin
              n.st = fan_ctrl_pkg::ENG_STOP;
            end else if (r.idx == fan_ctrl_pkg::IDX_REG && r.req.read) begin
              n.st = fan_ctrl_pkg::ENG_RESTART;
            end else if (r.idx == fan_ctrl_pkg::IDX_DATA || rx) begin
              if (rx) begin
                n.rd = r.sh;
              end
              n.st = fan_ctrl_pkg::ENG_STOP;
            end else begin
              n.idx = 3'(r.idx + 3'h1);
              n.sh = byteFor(3'(r.idx + 3'h1), r.req);
              n.slot = 4'h0;
            end
          end
        endcase
      end
      fan_ctrl_pkg::ENG_RESTART: if (tick) begin
        unique case (r.qtr)
          2'h0: n.sdaOe = 1'b0;
          2'h1: n.sclOe = 1'b0;
          2'h2: n.sdaOe = 1'b1;
          2'h3: begin
            n.sclOe = 1'b1;
            n.st = fan_ctrl_pkg::ENG_BIT;
            n.idx = fan_ctrl_pkg::IDX_ADDR_RD;
            n.sh = byteFor(fan_ctrl_pkg::IDX_ADDR_RD, r.req);
            n.slot = 4'h0;
          end
        endcase
      end
      fan_ctrl_pkg::ENG_STOP: if (tick) begin
        unique case (r.qtr)
          2'h0: n.sdaOe = 1'b1;
          2'h1: n.sclOe = 1'b0;
          2'h2: n.sdaOe = 1'b0;
          2'h3: begin
            n.st = fan_ctrl_pkg::ENG_IDLE;
            n.done = 1'b1;
          end
        endcase
      end
      default: n.st = fan_ctrl_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.sdaSync <= 3'h7;
      r.sdaF <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reqReady = (r.st == fan_ctrl_pkg::ENG_IDLE);
  assign done     = r.done;
  assign ackErr   = r.ackErr;
  assign rdData   = r.rd;
  assign sclOe    = r.sclOe;
  assign sdaOe    = r.sdaOe;

endmodule

`default_nettype wire

/* hdl/fan_speed_i2c_control.sv */
// fan controller supervisor: setup, speed select, alarm polling and indicators
`default_nettype none

module fan_speed_i2c_control #(
  parameter int unsigned QUARTER       = fan_ctrl_pkg::QUARTER_CYCLES,
  parameter int unsigned SETTLE_CYCLES = fan_ctrl_pkg::SETTLE_CYCLES,
  parameter int unsigned POLL_CYCLES   = fan_ctrl_pkg::POLL_CYCLES,
  parameter logic [6:0]  CHIP_ADDR     = fan_ctrl_pkg::CHIP_ADDR,
  parameter logic [7:0]  SPEED_LOW     = fan_ctrl_pkg::SPEED_LOW,
  parameter logic [7:0]  SPEED_HIGH    = fan_ctrl_pkg::SPEED_HIGH
) (
  input  wire logic       clk_sys,          // system clock, 100 MHz
  input  wire logic       rst,              // async reset, high
  input  wire logic       speedSelectInput, // switch: 0 low speed, 1 high speed
  input  wire logic       alarmClearN,      // push button, low while pressed
  input  wire logic       sclIn,            // clock line level (unused, no stretching)
  output logic            sclOut,           // clock line drive value, always low
  output logic            sclOe,            // clock line pulled low
  input  wire logic       sdaIn,            // data line level
  output logic            sdaOut,           // data line drive value, always low
  output logic            sdaOe,            // data line pulled low
  output logic [3:0]      alarmLed,         // latched alarm indicators
  output logic            configDone,       // chip set up and speed written
  output logic            linkFault         // last transfer lacked an acknowledge
);

  if (SETTLE_CYCLES < 1 || POLL_CYCLES < 1) begin : g_chk
    $error("fan_speed_i2c_control: counts must be at least one");
  end

  typedef struct packed {
    fan_ctrl_pkg::sup_state_t st;
    logic                     pend;
    logic [31:0]              cnt;
    logic [3:0]               leds;
    logic                     cfgDone;
    logic                     fault;
    logic                     spdApplied;
    logic [2:0]               spdSync;
    logic                     spdF;
    logic [2:0]               btnSync;
    logic                     btnF;
    logic                     pinLow;
  } sup_regs_t;

  sup_regs_t r, n;

  logic                    reqValid;
  logic                    reqReady;
  logic                    engDone;
  logic                    engErr;
  logic [7:0]              rdData;
  fan_ctrl_pkg::link_req_t req;
  logic                    press;
  logic                    newSpeed;
  logic [7:0]              flags;

  link_master #(
    .QUARTER (QUARTER)
  ) u_link (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .reqValid (reqValid),
    .req      (req),
    .reqReady (reqReady),
    .done     (engDone),
    .ackErr   (engErr),
    .rdData   (rdData),
    .sdaIn    (sdaIn),
    .sclOe    (sclOe),
    .sdaOe    (sdaOe)
  );

  always_comb begin
    n = r;
    // ==========================================================================
    // pin synchronisers: a change counts once stages two and three agree
    n.spdSync = {r.spdSync[1:0], speedSelectInput};
    n.btnSync = {r.btnSync[1:0], alarmClearN};
    if (r.spdSync[2] == r.spdSync[1]) begin
      n.spdF = r.spdSync[2];
    end
    press = 1'b0;
    if (r.btnSync[2] == r.btnSync[1]) begin
      n.btnF = r.btnSync[2];
      press = r.btnF && !r.btnSync[2];
    end
    newSpeed = (r.spdF != r.spdApplied);

    // ==========================================================================
    // request selection
    req.dev = CHIP_ADDR;
    req.read = 1'b0;
    req.regAddr = fan_ctrl_pkg::REG_CONFIG;
    req.data = fan_ctrl_pkg::CONFIG_VALUE;
    unique case (r.st)
      fan_ctrl_pkg::SUP_SPEED: begin
        req.regAddr = fan_ctrl_pkg::REG_SPEED;
        req.data = r.spdF ? SPEED_HIGH : SPEED_LOW; // RULE4 RULE5
      end
      fan_ctrl_pkg::SUP_POLL: begin
        req.read = 1'b1; // RULE12
        req.regAddr = fan_ctrl_pkg::REG_ALARM;
        req.data = 8'h00;
      end
      default: ;
    endcase
    reqValid = !r.pend && reqReady && (r.st == fan_ctrl_pkg::SUP_CONFIG ||
               r.st == fan_ctrl_pkg::SUP_SPEED || r.st == fan_ctrl_pkg::SUP_POLL);
    if (reqValid) begin
      n.pend = 1'b1;
      // record the value this write carries, so a flip during the write is still seen
      if (r.st == fan_ctrl_pkg::SUP_SPEED) begin
        n.spdApplied = r.spdF;
      end
    end

    // ==========================================================================
    // indicators: a flag read in the same cycle as a press still lights
    flags = rdData & fan_ctrl_pkg::ALARM_USED; // RULE11
    n.leds = press ? 4'h0 : r.leds; // RULE8

    // ==========================================================================
    // sequencing
    unique case (r.st)
      fan_ctrl_pkg::SUP_CONFIG: begin
        if (engDone) begin
          n.pend = 1'b0;
          n.fault = engErr;
          if (!engErr) begin
            n.st = fan_ctrl_pkg::SUP_SPEED; // RULE1
          end
        end
      end
      fan_ctrl_pkg::SUP_SPEED: begin
        if (engDone) begin
          n.pend = 1'b0;
          n.fault = engErr;
          if (!engErr) begin
            n.st = fan_ctrl_pkg::SUP_SETTLE;
            n.cnt = 32'h0000_0000;
            n.cfgDone = 1'b1;
          end
        end
      end
      fan_ctrl_pkg::SUP_SETTLE: begin
        // no alarm checks while the fan ramps to its new target
        n.cnt = 32'(r.cnt + 32'h1);
        if (newSpeed) begin
          n.st = fan_ctrl_pkg::SUP_SPEED;
        end else if (r.cnt == 32'(SETTLE_CYCLES - 1)) begin // RULE6
          n.st = fan_ctrl_pkg::SUP_WAIT;
          n.cnt = 32'h0000_0000;
        end
      end
      fan_ctrl_pkg::SUP_WAIT: begin
        n.cnt = 32'(r.cnt + 32'h1);
        if (newSpeed) begin
          n.st = fan_ctrl_pkg::SUP_SPEED;
        end else if (r.cnt == 32'(POLL_CYCLES - 1)) begin // RULE12
          n.st = fan_ctrl_pkg::SUP_POLL;
        end
      end
      fan_ctrl_pkg::SUP_POLL: begin
        if (engDone) begin
          n.pend = 1'b0;
          n.fault = engErr;
          n.st = fan_ctrl_pkg::SUP_WAIT;
          n.cnt = 32'h0000_0000;
          if (!engErr) begin
            n.leds = n.leds | flags[3:0]; // RULE7 RULE9 RULE10
          end
        end
      end
      default: n.st = fan_ctrl_pkg::SUP_CONFIG;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.leds <= fan_ctrl_pkg::ALARM_RESET[3:0];
      r.btnSync <= 3'h7;
      r.btnF <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign alarmLed   = r.leds;
  assign configDone = r.cfgDone;
  assign linkFault  = r.fault;
  assign sclOut     = r.pinLow;
  assign sdaOut     = r.pinLow;

endmodule

`default_nettype wire

/* verif/fan_chip_model.sv */
// behavioural fan controller chip on the two-wire link
`default_nettype none
module fan_chip_model #(
  parameter logic [6:0] ADDR = 7'h1B
) (
  input  wire logic       scl,     // clock line level
  input  wire logic       sda,     // data line level
  input  wire logic [7:0] alarmIn, // raw alarm conditions
  input  wire logic       nackAll, // refuse every byte
  output logic            sdaOe    // pull data line low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [16] = '{default: 8'h00};
  logic [7:0] sh = 8'h00;
  logic [7:0] out = 8'h00;
  logic [3:0] ptr = 4'h0;
  logic       sel = 1'b0;
  logic       rdMode = 1'b0;
  int         bitN = 0;
  int         byteN = 0;
  int         readCount = 0;
  initial sdaOe = 1'b0;
  // ========
  // start and stop: data moves while the clock line is high
  always @(negedge sda) if (scl === 1'b1) begin
    bitN = 0;
    byteN = 0;
    rdMode = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    bitN = 0;
    byteN = 0;
    sdaOe = 1'b0;
  end
  always @(posedge scl) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    bitN = bitN + 1;
  end
  always @(negedge scl) begin
    if (bitN == 8 && !(rdMode && byteN > 0)) begin
      if (byteN == 0) begin
        sel = (sh[7:1] == ADDR);
        rdMode = sh[0];
      end else if (byteN == 1) ptr = sh[3:0];
      else regs[ptr] = sh;
      sdaOe = sel && !nackAll;
    end else if (bitN == 8) begin
      sdaOe = 1'b0;
      readCount++;
    end else if (bitN == 9) begin
      bitN = 0;
      byteN++;
      sdaOe = 1'b0;
      if (rdMode && sel && byteN == 1) begin
        // upper flags: three always zero, one only on a sibling part
        out = (ptr == 4'hC) ? {3'b000, alarmIn[4:0]} : regs[ptr];
        sdaOe = !out[7];
      end
    end else if (rdMode && sel && byteN == 1 && bitN > 0) sdaOe = !out[7 - bitN];
  end
endmodule
`default_nettype wire

/* verif/fan_speed_i2c_control_sva.sv */
// assertions on the fan supervisor ports
`default_nettype none
module fan_speed_i2c_control_sva #(
  parameter int unsigned QUARTER = fan_ctrl_pkg::QUARTER_CYCLES
) (
  input wire logic       clk_sys,          // system clock
  input wire logic       rst,              // async reset
  input wire logic       speedSelectInput, // speed switch
  input wire logic       alarmClearN,      // clear button
  input wire logic       sclIn,            // clock line
  input wire logic       sclOut,           // clock drive value
  input wire logic       sclOe,            // clock pull low
  input wire logic       sdaIn,            // data line
  input wire logic       sdaOut,           // data drive value
  input wire logic       sdaOe,            // data pull low
  input wire logic [3:0] alarmLed,         // indicators
  input wire logic       configDone,       // setup finished
  input wire logic       linkFault         // missing acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned gap;
  int unsigned pressAge;
  logic        sclPrev;
  logic        sdaPrev;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ========
  // saturating ages so long runs never wrap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap      <= 1000;
      pressAge <= 1000;
      sclPrev  <= 1'b0;
      sdaPrev  <= 1'b0;
    end else begin
      sclPrev  <= sclOe;
      sdaPrev  <= sdaOe;
      gap      <= (sclOe != sclPrev || sdaOe != sdaPrev) ? 0 : (gap < 1000 ? gap + 1 : gap);
      pressAge <= !alarmClearN ? 0 : (pressAge < 1000 ? pressAge + 1 : pressAge);
    end
  end
  property p_drive_low;
    sclOut == 1'b0 && sdaOut == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("line drive value not low");
  property p_reset_idle;
    $fell(rst) |-> !sclOe && !sdaOe && !configDone && alarmLed == 4'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_quarter_steps;
    (sclOe != sclPrev || sdaOe != sdaPrev) |-> gap >= QUARTER - 1;
  endproperty
  a_quarter_steps: assert property (p_quarter_steps)
    else $error("line change faster than a quarter");
  property p_led_fall_press;
    (($past(alarmLed) & ~alarmLed) != 4'h0) |-> pressAge <= 10;
  endproperty
  a_led_fall_press: assert property (p_led_fall_press)
    else $error("indicator dropped without a press");
  property p_led_rise_idle;
    ((alarmLed & ~$past(alarmLed)) != 4'h0) |-> !sclOe && !sdaOe;
  endproperty
  a_led_rise_idle: assert property (p_led_rise_idle)
    else $error("indicator lit outside a finished read");
  property p_cfg_sticky;
    configDone |=> configDone;
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky)
    else $error("setup flag dropped");
  property p_cfg_rise_idle;
    $rose(configDone) |-> !sclOe && !sdaOe;
  endproperty
  a_cfg_rise_idle: assert property (p_cfg_rise_idle)
    else $error("setup flag rose mid transfer");
  property p_fault_rise_idle;
    $rose(linkFault) |-> !sclOe && !sdaOe;
  endproperty
  a_fault_rise_idle: assert property (p_fault_rise_idle)
    else $error("fault rose mid transfer");
  c_led: cover property ($rose(|alarmLed));
  c_cfg: cover property ($rose(configDone));
  c_fault: cover property ($rose(linkFault));
  c_clear: cover property ($fell(|alarmLed));
endmodule
bind fan_speed_i2c_control fan_speed_i2c_control_sva #(.QUARTER(QUARTER)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .speedSelectInput(speedSelectInput),
  .alarmClearN(alarmClearN), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .alarmLed(alarmLed),
  .configDone(configDone), .linkFault(linkFault));
`default_nettype wire

/* verif/fan_speed_i2c_control_tb_top.sv */
// self-checking bench for the fan supervisor against a chip model
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module fan_speed_i2c_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 200;
  logic        clk_sys;
  logic        rst;
  logic        speedSelectInput;
  logic        alarmClearN;
  logic        nackAll;
  logic        chipOe;
  logic        sclOut;
  logic        sclOe;
  logic        sdaOut;
  logic        sdaOe;
  logic        configDone;
  logic        linkFault;
  logic        busy;
  logic [3:0]  alarmLed;
  logic [3:0]  accLed = 4'h0;
  logic [7:0]  alarmIn;
  logic [7:0]  flags;
  logic [31:0] seed = 32'hCEABAC5A;
  int          errCount = 0;
  int          nTests = 0;
  int          cycles = 0;
  // open-drain lines with pull-ups
  wire         sclLine = !sclOe;
  wire         sdaLine = !(sdaOe || chipOe);
  fan_speed_i2c_control #(.QUARTER(4), .SETTLE_CYCLES(SETTLE), .POLL_CYCLES(50)) dut (
    .clk_sys(clk_sys), .rst(rst), .speedSelectInput(speedSelectInput),
    .alarmClearN(alarmClearN), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .alarmLed(alarmLed),
    .configDone(configDone), .linkFault(linkFault));
  fan_chip_model #(.ADDR(fan_ctrl_pkg::CHIP_ADDR)) chip (.scl(sclLine), .sda(sdaLine),
    .alarmIn(alarmIn), .nackAll(nackAll), .sdaOe(chipOe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] expLed(input logic [3:0] acc, input logic [7:0] f);
    return acc | f[3:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic waitReads(input int n);
    int base;
    base = chip.readCount;
    for (int i = 0; i < 4000 && chip.readCount < base + n; i++) tick(1);
  endtask
  task automatic waitSpeed(input logic [7:0] v);
    for (int i = 0; i < 4000 && chip.regs[0] !== v; i++) tick(1);
  endtask
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ======== hang guard, several times the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      errCount++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    speedSelectInput = 1'b0;
    alarmClearN = 1'b1;
    nackAll = 1'b0;
    alarmIn = 8'h00;
    tick(3);
    rst = 1'b0;
    for (int i = 0; i < 4000 && configDone !== 1'b1; i++) tick(1);
    `CHK(configDone, 1'b1)
    `CHK(chip.regs[2], fan_ctrl_pkg::CONFIG_VALUE)
    `CHK(chip.regs[0], fan_ctrl_pkg::SPEED_LOW)
    $display("test low speed ends");
    speedSelectInput = 1'b1;
    waitSpeed(fan_ctrl_pkg::SPEED_HIGH);
    `CHK(chip.regs[0], fan_ctrl_pkg::SPEED_HIGH)
    // let the write finish, then the lines must stay quiet for the whole settle time
    tick(40);
    busy = 1'b0;
    for (int i = 0; i < SETTLE; i++) begin
      tick(1);
      busy = busy | sclOe | sdaOe;
    end
    `CHK(busy, 1'b0)
    `CHK(chip.readCount, 0)
    $display("test high speed ends");
    for (int k = 0; k < 6; k++) begin
      flags = (k == 0) ? 8'hF0 : (k == 1) ? 8'h08 : seed[7:0];
      seed = lfsr(seed);
      alarmIn = flags;
      waitReads(2);
      // read byte ends about 33 cycles before the indicators update
      tick(40);
      accLed = expLed(accLed, flags);
      `CHK(alarmLed, accLed)
    end
    $display("test alarm latch ends");
    alarmIn = 8'h00;
    waitReads(2);
    tick(40);
    alarmClearN = 1'b0;
    tick(6);
    alarmClearN = 1'b1;
    tick(6);
    `CHK(alarmLed, 4'h0)
    alarmIn = 8'h04;
    waitReads(2);
    tick(40);
    `CHK(alarmLed, 4'h4)
    $display("test clear ends");
    nackAll = 1'b1;
    alarmIn = 8'h01;
    for (int i = 0; i < 4000 && linkFault !== 1'b1; i++) tick(1);
    `CHK(linkFault, 1'b1)
    `CHK(alarmLed, 4'h4)
    nackAll = 1'b0;
    for (int i = 0; i < 4000 && linkFault !== 1'b0; i++) tick(1);
    tick(20);
    `CHK(linkFault, 1'b0)
    `CHK(alarmLed, 4'h5)
    $display("test refused link ends");
    speedSelectInput = 1'b0;
    waitSpeed(fan_ctrl_pkg::SPEED_LOW);
    `CHK(chip.regs[0], fan_ctrl_pkg::SPEED_LOW)
    $display("test speed back ends");
    conclude();
  end
endmodule
`default_nettype wire
